// >>> rtl/emmc_defs.svh
/*
 * Offsets, field positions, reset values and codes of the error message
 * mask control.
 * Assumes a 4-bit register address and 16-bit register data.
 */
`ifndef EMMC_DEFS_SVH
`define EMMC_DEFS_SVH

`define EMMC_DATA_W          16
`define EMMC_OFS_SEL         4'h0
`define EMMC_OFS_CMD         4'h4
`define EMMC_OFS_STAT        4'h8
`define EMMC_OFS_ERR         4'hC

`define EMMC_MASK_PREFIX     7'h08
`define EMMC_SUFFIX_AUTO     4'h0
`define EMMC_SUFFIX_ALL_OFF  4'h7
`define EMMC_SUFFIX_MAX      4'h8
`define EMMC_SEL_RESET       4'h0

`define EMMC_CMD_SET_BIT     0
`define EMMC_CMD_CLR_BIT     1

`define EMMC_STAT_MASK_LSB   0
`define EMMC_STAT_REQ_LSB    4
`define EMMC_STAT_ACT_LSB    8
`define EMMC_STAT_MODE_LSB   12
`define EMMC_ERR_VALID_BIT   15

`define EMMC_ERR_NONE        8'h00
`define EMMC_ERR_IF_RANGE    8'h01
`define EMMC_ERR_IN_OVER     8'h02
`define EMMC_ERR_IN_UNDER    8'h03
`define EMMC_ERR_AUD_OVER    8'h04

`define EMMC_MASK_NONE       4'h0
`define EMMC_MASK_ALL        4'hF

`endif

// >>> rtl/emmc_pkg.sv
/*
 * Types of the error message mask control.
 * Mask bit 0 stands for error 01 (signal outside IF range), bit 1 for 02
 * (input overdriven), bit 2 for 03 (input underdriven), bit 3 for 04
 * (audio overdriven); a set bit means the error is masked.
 */
package emmc_pkg;

    typedef logic [3:0] emmc_mask_t;

    typedef enum logic [3:0] {
        EMMC_M_AM      = 4'h0,
        EMMC_M_FM      = 4'h1,
        EMMC_M_PM      = 4'h2,
        EMMC_M_RFPWR   = 4'h3,
        EMMC_M_FREQ    = 4'h4,
        EMMC_M_AFREQ   = 4'h5,
        EMMC_M_ADIST   = 4'h6,
        EMMC_M_IFLVL   = 4'h7,
        EMMC_M_TRFLVL  = 4'h8,
        EMMC_M_FERR    = 4'h9,
        EMMC_M_SNDMEAS = 4'hA,
        EMMC_M_EXTAUD  = 4'hB,
        EMMC_M_LOFREQ  = 4'hC,
        EMMC_M_IFFREQ  = 4'hD,
        EMMC_M_RFLVL   = 4'hE,
        EMMC_M_SPARE   = 4'hF
    } emmc_mode_t;

endpackage : emmc_pkg

// >>> rtl/emmc_auto_mask.sv
/*
 * Per-measurement mask used while the mask selection is automatic.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/100ps
`include "emmc_defs.svh"

module emmc_auto_mask
    import emmc_pkg::*;
(
    // measurement in progress
    input  emmc_mode_t mode_i,
    // mask it calls for
    output emmc_mask_t mask_o
);

    always_comb
    begin
        unique case (mode_i)
            EMMC_M_RFPWR,
            EMMC_M_RFLVL:   mask_o = 4'h9;
            EMMC_M_FREQ,
            EMMC_M_TRFLVL:  mask_o = 4'hE;
            EMMC_M_IFLVL,
            EMMC_M_FERR:    mask_o = `EMMC_MASK_ALL;
            EMMC_M_LOFREQ:  mask_o = `EMMC_MASK_ALL;
            EMMC_M_IFFREQ:  mask_o = `EMMC_MASK_ALL;
            EMMC_M_SNDMEAS: mask_o = `EMMC_MASK_NONE;
            EMMC_M_EXTAUD:  mask_o = `EMMC_MASK_NONE;
            // modulation and audio modes report everything
            default:        mask_o = `EMMC_MASK_NONE;
        endcase
    end

endmodule : emmc_auto_mask

// >>> rtl/emmc_code_conv.sv
/*
 * Conversion between mask suffix codes and mask bit sets, both ways.
 * Purely combinational. Codes above 8 never reach the code input.
 */
`timescale 1ns/100ps
`include "emmc_defs.svh"

module emmc_code_conv
    import emmc_pkg::*;
(
    // suffix code to mask
    input  logic [3:0] code_i,
    output emmc_mask_t mask_o,
    // mask to the suffix code that gives it
    input  emmc_mask_t mask_i,
    output logic [3:0] code_o
);

    always_comb
    begin
        unique case (code_i)
            4'h1:    mask_o = 4'h1;
            4'h2:    mask_o = 4'h6;
            4'h3:    mask_o = 4'h7;
            4'h4:    mask_o = 4'h8;
            4'h5:    mask_o = 4'h9;
            4'h6:    mask_o = 4'hE;
            4'h7:    mask_o = `EMMC_MASK_ALL;
            default: mask_o = `EMMC_MASK_NONE;
        endcase
    end

    always_comb
    begin
        unique case (mask_i)
            4'h1:           code_o = 4'h1;
            4'h6:           code_o = 4'h2;
            4'h7:           code_o = 4'h3;
            4'h8:           code_o = 4'h4;
            4'h9:           code_o = 4'h5;
            4'hE:           code_o = 4'h6;
            `EMMC_MASK_ALL: code_o = 4'h7;
            // the empty mask takes code 8; other masks with no suffix of their own never arise
            default:        code_o = `EMMC_SUFFIX_MAX;
        endcase
    end

endmodule : emmc_code_conv

// >>> rtl/emmc_top.sv
/*
 * Error message mask control: keeps the mask selection, works out which
 * of errors 01..04 may be reported, picks the error code to display, and
 * restricts audio autoranging while error 04 is masked.
 * Assumes all inputs are synchronous to MCLK_I, keypad entries arrive
 * already parsed into prefix and suffix, and software on the register
 * port acts as the remote bus controller.
 */
// Decided for this implementation: the register offsets and the plain strobed port.
// Notes on behaviour
// - an unmasked sensed condition shows its numeric error code
// - maskable errors are 01 IF range, 02 over, 03 under, 04 audio
// - automatic mask follows measurement mode per the fixed table
// - automatic RF power and RF level mask errors 01 and 04
// - automatic LO frequency display masks all four errors
// - automatic IF frequency display masks all four errors
// - automatic noise-distortion measure masks none
// - automatic external audio level masks none
// - manual codes 1..7 map to their fixed mask sets
// - code 8 enables all errors: calibrated receiver mode
// - manual codes 1..8 override the automatic mask until replaced
// - the disable key acts exactly like mask code 7
// - with error 04 masked audio range may go up, never down
// - non-maskable errors are still reported whatever the mask
// - masked errors are visible on requested and actual displays
// - display digit holds the mask function's current suffix
// - an entry flagged as invalid sequence leaves mask unchanged
`timescale 1ns/100ps
`include "emmc_defs.svh"

module emmc_top
    import emmc_pkg::*;
(
    // clock and reset
    input  logic                    MCLK_I,
    input  logic                    SRST_I,
    // register port
    input  logic [3:0]              REG_ADDR_I,
    input  logic [`EMMC_DATA_W-1:0] REG_WDATA_I,
    input  logic                    REG_WR_I,
    input  logic                    REG_RD_I,
    output logic [`EMMC_DATA_W-1:0] REG_RDATA_O,
    // keypad entries
    input  logic                    KEY_STB_I,
    input  logic [6:0]              KEY_PREFIX_I,
    input  logic [3:0]              KEY_SUFFIX_I,
    input  logic                    KEY_SEQ_ERR_I,
    input  logic                    DIS_KEY_I,
    // measurement and sensed conditions
    input  emmc_mode_t              MEAS_MODE_I,
    input  logic [3:0]              COND_I,
    input  logic                    OTHER_ERR_I,
    input  logic [7:0]              OTHER_CODE_I,
    // audio autorange requests
    input  logic                    AUD_UP_REQ_I,
    input  logic                    AUD_DN_REQ_I,
    // error reporting
    output logic [3:0]              MASK_O,
    output logic [3:0]              ERR_FLAGS_O,
    output logic                    ERR_VALID_O,
    output logic [7:0]              ERR_CODE_O,
    output logic                    CAL_RX_O,
    // settings display digits
    output logic [3:0]              REQ_DIGIT_O,
    output logic [3:0]              ACT_DIGIT_O,
    // audio range steps
    output logic                    AUD_UP_O,
    output logic                    AUD_DN_O
);

    logic [3:0]              sel_q;
    logic [3:0]              sel_d;
    emmc_mask_t              auto_mask;
    emmc_mask_t              man_mask;
    emmc_mask_t              eff_mask;
    logic [3:0]              auto_code;
    logic [3:0]              act_code;
    logic [3:0]              reported;
    logic                    wr_sel;
    logic                    wr_cmd;
    logic                    key_ok;

    emmc_mask_t              mask_q;
    emmc_mask_t              mask_d;
    logic [3:0]              flags_q;
    logic [3:0]              flags_d;
    logic                    valid_q;
    logic                    valid_d;
    logic [7:0]              code_q;
    logic [7:0]              code_d;
    logic                    cal_q;
    logic                    cal_d;
    logic [3:0]              req_q;
    logic [3:0]              act_q;
    logic                    up_q;
    logic                    up_d;
    logic                    dn_q;
    logic                    dn_d;
    logic [`EMMC_DATA_W-1:0] rdata_q;
    logic [`EMMC_DATA_W-1:0] rdata_d;

    emmc_auto_mask u_auto (
        .mode_i (MEAS_MODE_I),
        .mask_o (auto_mask)
    );

    emmc_code_conv u_conv (
        .code_i (sel_q),
        .mask_o (man_mask),
        .mask_i (auto_mask),
        .code_o (auto_code)
    );

    // mask selection

    assign wr_sel = REG_WR_I && (REG_ADDR_I == `EMMC_OFS_SEL);
    assign wr_cmd = REG_WR_I && (REG_ADDR_I == `EMMC_OFS_CMD);
    assign key_ok = KEY_STB_I && !KEY_SEQ_ERR_I
                 && (KEY_PREFIX_I == `EMMC_MASK_PREFIX)
                 && (KEY_SUFFIX_I <= `EMMC_SUFFIX_MAX);

    // the remote port wins over the keypad when both act in one cycle
    always_comb
    begin
        sel_d = sel_q;
        if (wr_sel)
        begin
            if (REG_WDATA_I[3:0] <= `EMMC_SUFFIX_MAX)
                sel_d = REG_WDATA_I[3:0];
        end
        else if (wr_cmd)
        begin
            if (REG_WDATA_I[`EMMC_CMD_SET_BIT])
                sel_d = `EMMC_SUFFIX_ALL_OFF;
            else if (REG_WDATA_I[`EMMC_CMD_CLR_BIT]
                     && sel_q == `EMMC_SUFFIX_ALL_OFF)
                sel_d = `EMMC_SUFFIX_AUTO;
        end
        else if (DIS_KEY_I)
            sel_d = `EMMC_SUFFIX_ALL_OFF;
        else if (key_ok)
            sel_d = KEY_SUFFIX_I;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            sel_q <= `EMMC_SEL_RESET;
        else
            sel_q <= sel_d;
    end

    // effective mask and reporting

    // no pipeline between mode, selection and mask
    assign eff_mask = (sel_q == `EMMC_SUFFIX_AUTO) ? auto_mask
                                                   : man_mask;
    assign act_code = (sel_q == `EMMC_SUFFIX_AUTO) ? auto_code
                                                   : sel_q;
    assign reported = COND_I & ~eff_mask;

    always_comb
    begin
        mask_d  = eff_mask;
        flags_d = reported;
        cal_d   = (sel_q == `EMMC_SUFFIX_MAX);
        valid_d = 1'b1;
        // lowest code first; others only when no maskable one shows
        if (reported[0])
            code_d = `EMMC_ERR_IF_RANGE;
        else if (reported[1])
            code_d = `EMMC_ERR_IN_OVER;
        else if (reported[2])
            code_d = `EMMC_ERR_IN_UNDER;
        else if (reported[3])
            code_d = `EMMC_ERR_AUD_OVER;
        else if (OTHER_ERR_I)
            code_d = OTHER_CODE_I;
        else
        begin
            code_d  = `EMMC_ERR_NONE;
            valid_d = 1'b0;
        end
        // down-range blocked while 04 is masked, so peaks do not bounce it
        up_d = AUD_UP_REQ_I;
        dn_d = AUD_DN_REQ_I && !AUD_UP_REQ_I && !eff_mask[3];
    end

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            mask_q  <= `EMMC_MASK_NONE;
            flags_q <= 4'h0;
            valid_q <= 1'b0;
            code_q  <= `EMMC_ERR_NONE;
            cal_q   <= 1'b0;
            req_q   <= `EMMC_SEL_RESET;
            act_q   <= `EMMC_SUFFIX_MAX;
            up_q    <= 1'b0;
            dn_q    <= 1'b0;
        end
        else
        begin
            mask_q  <= mask_d;
            flags_q <= flags_d;
            valid_q <= valid_d;
            code_q  <= code_d;
            cal_q   <= cal_d;
            req_q   <= sel_q;
            act_q   <= act_code;
            up_q    <= up_d;
            dn_q    <= dn_d;
        end
    end

    // register reads, data one cycle after the strobe

    always_comb
    begin
        rdata_d = '0;
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                `EMMC_OFS_SEL:
                    rdata_d[3:0] = sel_q;
                `EMMC_OFS_STAT:
                begin
                    rdata_d[`EMMC_STAT_MASK_LSB+:4] = eff_mask;
                    rdata_d[`EMMC_STAT_REQ_LSB+:4]  = sel_q;
                    rdata_d[`EMMC_STAT_ACT_LSB+:4]  = act_code;
                    rdata_d[`EMMC_STAT_MODE_LSB+:4] = MEAS_MODE_I;
                end
                `EMMC_OFS_ERR:
                begin
                    rdata_d[7:0] = code_q;
                    rdata_d[`EMMC_ERR_VALID_BIT] = valid_q;
                end
                // command register and unmapped addresses read zero
                default:
                    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge MCLK_I)
    begin
        if (SRST_I)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign REG_RDATA_O = rdata_q;
    assign MASK_O      = mask_q;
    assign ERR_FLAGS_O = flags_q;
    assign ERR_VALID_O = valid_q;
    assign ERR_CODE_O  = code_q;
    assign CAL_RX_O    = cal_q;
    assign REQ_DIGIT_O = req_q;
    assign ACT_DIGIT_O = act_q;
    assign AUD_UP_O    = up_q;
    assign AUD_DN_O    = dn_q;

    // checks

    a_flags_unmasked: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        (ERR_FLAGS_O & MASK_O) == 4'h0
    ) else $error("masked error reported");

    a_cond_shows_code: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        COND_I[1] && !eff_mask[1] && !COND_I[0]
        |=> ERR_VALID_O && ERR_CODE_O == 8'h02
    ) else $error("unmasked error 02 not shown");

    a_auto_table: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q == 4'h0 && MEAS_MODE_I == EMMC_M_FREQ
        |=> MASK_O == 4'hE
    ) else $error("frequency auto mask wrong");

    a_auto_rflvl: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q == 4'h0 && MEAS_MODE_I == EMMC_M_RFLVL
        |=> MASK_O == 4'h9
    ) else $error("rf level auto mask wrong");

    a_auto_lofreq: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q == 4'h0 && MEAS_MODE_I == EMMC_M_LOFREQ
        |=> MASK_O == 4'hF
    ) else $error("lo frequency auto mask wrong");

    a_auto_sndmeas: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q == 4'h0 && MEAS_MODE_I == EMMC_M_SNDMEAS
        |=> MASK_O == 4'h0
    ) else $error("noise distortion auto mask wrong");

    a_manual_wins: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q == 4'h6 && MEAS_MODE_I == EMMC_M_AM
        |=> MASK_O == 4'hE
    ) else $error("manual code did not override");

    a_cal_receiver: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q == 4'h8 |=> MASK_O == 4'h0 && CAL_RX_O
    ) else $error("calibrated receiver mode wrong");

    a_disable_key: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        DIS_KEY_I && !REG_WR_I |=> sel_q == 4'h7 ##1 MASK_O == 4'hF
    ) else $error("disable key did not mask all");

    a_seq_err_hold: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        KEY_STB_I && KEY_SEQ_ERR_I && !REG_WR_I && !DIS_KEY_I
        |=> $stable(sel_q)
    ) else $error("invalid entry changed selection");

    a_bad_suffix: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        REG_WR_I && REG_ADDR_I == 4'h0 && REG_WDATA_I[3:0] > 4'h8
        |=> $stable(sel_q)
    ) else $error("bad suffix accepted");

    a_audio_no_down: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        MASK_O[3] |-> !AUD_DN_O
    ) else $error("down-range while 04 masked");

    a_other_error: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        OTHER_ERR_I && reported == 4'h0
        |=> ERR_VALID_O && ERR_CODE_O == $past(OTHER_CODE_I)
    ) else $error("non-maskable error lost");

    a_display_match: assert property (
        @(posedge MCLK_I) disable iff (SRST_I)
        sel_q != 4'h0 ##1 $stable(sel_q) |-> ACT_DIGIT_O == REQ_DIGIT_O
    ) else $error("actual digit differs from manual code");

endmodule : emmc_top

// >>> verif/emmc_op_model.sv
/*
 * Operator and remote controller model: register bus master and keypad.
 * Assumes the block samples every input on the rising clock edge.
 */
`timescale 1ns/100ps
`include "emmc_defs.svh"

module emmc_op_model (
    // clock
    input  logic        clk_i,
    // register port
    output logic [3:0]  reg_addr_o,
    output logic [15:0] reg_wdata_o,
    output logic        reg_wr_o,
    output logic        reg_rd_o,
    input  logic [15:0] reg_rdata_i,
    // keypad
    output logic        key_stb_o,
    output logic [6:0]  key_prefix_o,
    output logic [3:0]  key_suffix_o,
    output logic        key_seq_err_o,
    output logic        dis_key_o
);
    initial
    begin
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
        {key_stb_o, key_prefix_o, key_suffix_o, key_seq_err_o} = '0;
        dis_key_o = 1'b0;
    end

    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge clk_i);
        reg_wr_o    <= 1'b0;
        // stale data would hide a write taken one cycle late
        reg_wdata_o <= ~d;
    endtask : reg_wr

    task reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge clk_i);
        reg_rd_o   <= 1'b0;
        #1 d = reg_rdata_i;
    endtask : reg_rd

    task key(input logic [6:0] p, input logic [3:0] s, input logic e);
        @(posedge clk_i);
        key_stb_o     <= 1'b1;
        key_prefix_o  <= p;
        key_suffix_o  <= s;
        key_seq_err_o <= e;
        @(posedge clk_i);
        key_stb_o     <= 1'b0;
        key_seq_err_o <= 1'b0;
        key_prefix_o  <= ~p;
        key_suffix_o  <= ~s;
    endtask : key

    task dis_press;
        @(posedge clk_i);
        dis_key_o <= 1'b1;
        @(posedge clk_i);
        dis_key_o <= 1'b0;
    endtask : dis_press

    // set sends the suppress command, clear sends its release
    task remote(input logic set);
        reg_wr(`EMMC_OFS_CMD, set ? 16'h0001 : 16'h0002);
    endtask : remote
endmodule : emmc_op_model

// >>> verif/error_message_mask_control_tb.sv
/*
 * Self-checking bench of the error message mask control.
 * Assumes the operator model drives register port and keypad, while the
 * bench drives measurement mode, conditions and autorange requests.
 */
`timescale 1ns/100ps
`include "emmc_defs.svh"

module error_message_mask_control_tb
    import emmc_pkg::*;
;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] rd;
    logic        wr;
    logic        rdstb;
    logic        stb;
    logic        seq_err;
    logic        dis;
    logic [6:0]  prefix;
    logic [3:0]  suffix;
    logic [3:0]  cond = 4'h0;
    logic [3:0]  mask;
    logic [3:0]  flags;
    logic [3:0]  req_dig;
    logic [3:0]  act_dig;
    emmc_mode_t  mode = EMMC_M_AM;
    logic        other = 1'b0;
    logic        up = 1'b0;
    logic        dn = 1'b0;
    logic [7:0]  other_code = 8'h07;
    logic [7:0]  code;
    logic        valid;
    logic        cal;
    logic        aud_up;
    logic        aud_dn;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    // bit n set masks error n+1
    localparam logic [3:0] AUTO_TAB [16] = '{4'h0, 4'h0, 4'h0, 4'h9,
        4'hE, 4'h0, 4'h0, 4'hF, 4'hE, 4'hF, 4'h0, 4'h0, 4'hF, 4'hF,
        4'h9, 4'h0};
    localparam logic [3:0] MAN_TAB [9] = '{4'h0, 4'h1, 4'h6, 4'h7,
        4'h8, 4'h9, 4'hE, 4'hF, 4'h0};

    always #12.5 clk = ~clk;

    emmc_top dut_u (
        .MCLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rdstb),
        .REG_RDATA_O(rdata), .KEY_STB_I(stb), .KEY_PREFIX_I(prefix),
        .KEY_SUFFIX_I(suffix), .KEY_SEQ_ERR_I(seq_err), .DIS_KEY_I(dis),
        .MEAS_MODE_I(mode), .COND_I(cond), .OTHER_ERR_I(other),
        .OTHER_CODE_I(other_code), .AUD_UP_REQ_I(up), .AUD_DN_REQ_I(dn),
        .MASK_O(mask), .ERR_FLAGS_O(flags), .ERR_VALID_O(valid),
        .ERR_CODE_O(code), .CAL_RX_O(cal), .REQ_DIGIT_O(req_dig),
        .ACT_DIGIT_O(act_dig), .AUD_UP_O(aud_up), .AUD_DN_O(aud_dn)
    );

    emmc_op_model op_u (
        .clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rdstb), .reg_rdata_i(rdata),
        .key_stb_o(stb), .key_prefix_o(prefix), .key_suffix_o(suffix),
        .key_seq_err_o(seq_err), .dis_key_o(dis)
    );

    // only the automatic mask values reach this
    function automatic logic [3:0] act_of(input logic [3:0] m);
        case (m)
            4'h9:    return 4'h5;
            4'hE:    return 4'h6;
            4'hF:    return 4'h7;
            default: return 4'h8;
        endcase
    endfunction : act_of

    task results;
        $display("mismatches %0d comparisons %0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    task chk(input string nm, input logic [15:0] exp,
             input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task set_mode(input emmc_mode_t m);
        @(posedge clk);
        mode <= m;
        step(2);
    endtask : set_mode

    task chk_sel(input logic [3:0] m, input logic [3:0] rq,
                 input logic [3:0] ac);
        chk("mask digits", {4'h0, m, rq, ac},
            {4'h0, mask, req_dig, act_dig});
    endtask : chk_sel

    task t_auto;
        logic [3:0] m;
        for (int i = 0; i < 16; i++)
        begin
            set_mode(emmc_mode_t'(i[3:0]));
            m = AUTO_TAB[i];
            chk_sel(m, 4'h0, act_of(m));
        end
    endtask : t_auto

    task t_manual;
        for (int k = 0; k < 2; k++)
        begin
            set_mode(k ? EMMC_M_IFLVL : EMMC_M_AM);
            for (int c = 1; c < 9; c++)
            begin
                op_u.key(`EMMC_MASK_PREFIX, c[3:0], 1'b0);
                step(2);
                chk_sel(MAN_TAB[c], c[3:0], c[3:0]);
                chk("cal", {15'h0, c == 8}, {15'h0, cal});
            end
        end
        op_u.key(`EMMC_MASK_PREFIX, 4'h0, 1'b0);
        step(2);
        chk_sel(4'hF, 4'h0, 4'h7);
    endtask : t_manual

    task t_refuse;
        op_u.key(`EMMC_MASK_PREFIX, 4'h3, 1'b0);
        op_u.key(`EMMC_MASK_PREFIX, 4'h9, 1'b0);
        step(2);
        chk_sel(4'h7, 4'h3, 4'h3);
        op_u.key(7'h07, 4'h1, 1'b0);
        step(2);
        chk_sel(4'h7, 4'h3, 4'h3);
        op_u.key(`EMMC_MASK_PREFIX, 4'h1, 1'b1);
        step(2);
        chk_sel(4'h7, 4'h3, 4'h3);
        op_u.reg_wr(`EMMC_OFS_SEL, 16'h0009);
        step(2);
        chk_sel(4'h7, 4'h3, 4'h3);
    endtask : t_refuse

    task t_suppress;
        set_mode(EMMC_M_AM);
        op_u.dis_press();
        step(2);
        chk_sel(4'hF, 4'h7, 4'h7);
        op_u.reg_rd(`EMMC_OFS_STAT, rd);
        chk("status", 16'h077F, rd);
        // read data stand for one cycle only, then fall back to zero
        step(1);
        chk("read idle", 16'h0000, rdata);
        op_u.remote(1'b0);
        step(2);
        chk_sel(4'h0, 4'h0, 4'h8);
        op_u.remote(1'b1);
        step(2);
        chk_sel(4'hF, 4'h7, 4'h7);
        op_u.reg_wr(`EMMC_OFS_SEL, 16'h0005);
        step(2);
        chk_sel(4'h9, 4'h5, 4'h5);
        // release must not drop a plain manual selection
        op_u.remote(1'b0);
        step(2);
        chk_sel(4'h9, 4'h5, 4'h5);
        op_u.reg_rd(4'h2, rd);
        chk("unmapped read", 16'h0000, rd);
        op_u.reg_wr(`EMMC_OFS_SEL, 16'h0000);
    endtask : t_suppress

    task rep(input emmc_mode_t m, input logic [3:0] c, input logic o,
             input logic [7:0] ec, input logic [3:0] f);
        @(posedge clk);
        mode  <= m;
        cond  <= c;
        other <= o;
        step(2);
        chk("report", {3'h0, ec != 8'h00, ec, f},
            {3'h0, valid, code, flags});
    endtask : rep

    task t_report;
        rep(EMMC_M_AM, 4'hF, 1'b0, 8'h01, 4'hF);
        rep(EMMC_M_AM, 4'hC, 1'b0, 8'h03, 4'hC);
        op_u.reg_rd(`EMMC_OFS_ERR, rd);
        chk("error reg", 16'h8003, rd);
        rep(EMMC_M_AM, 4'h8, 1'b0, 8'h04, 4'h8);
        rep(EMMC_M_FREQ, 4'hE, 1'b0, 8'h00, 4'h0);
        rep(EMMC_M_FREQ, 4'hE, 1'b1, 8'h07, 4'h0);
        rep(EMMC_M_FREQ, 4'hF, 1'b1, 8'h01, 4'h1);
        rep(EMMC_M_RFPWR, 4'h6, 1'b0, 8'h02, 4'h6);
        rep(EMMC_M_AM, 4'h0, 1'b0, 8'h00, 4'h0);
    endtask : t_report

    task t_audio;
        for (int k = 0; k < 2; k++)
        begin
            op_u.key(`EMMC_MASK_PREFIX, k ? 4'h4 : 4'h0, 1'b0);
            @(posedge clk);
            dn <= 1'b1;
            step(2);
            chk("down step", {15'h0, ~k[0]}, {15'h0, aud_dn});
            @(posedge clk);
            dn <= 1'b0;
            up <= 1'b1;
            step(2);
            chk("up step", 16'h0001, {15'h0, aud_up});
            @(posedge clk);
            up <= 1'b0;
        end
    endtask : t_audio

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        chk("reset digits", 16'h0080, {mask, req_dig, act_dig, flags});
        chk("reset flags", 16'h0000,
            {3'h0, valid, code, aud_up, aud_dn, cal, 1'b0});
        @(posedge clk);
        srst <= 1'b0;
        t_auto();
        t_manual();
        t_refuse();
        t_suppress();
        t_report();
        t_audio();
        results();
    end

    // whole run needs well under 2000 cycles
    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end
endmodule : error_message_mask_control_tb
